// *** lpm_seq_pkg.sv ***
// constants and types of the low-power standby/halt sequencer
package lpm_seq_pkg;

  // =====================================================================
  // clock
  localparam int unsigned REF_CLK_HZ = 20_000_000;

  // =====================================================================
  // mode selection and divide codes
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_HALT = 2'h2;
  localparam logic [1:0] DIV_HALF = 2'h2;
  localparam logic [1:0] DIV_FULL = 2'h3;

  // =====================================================================
  // timing counts, in clock cycles
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] FLUSH_SHORT = 18'h00010;
  localparam logic [CNT_W-1:0] FLUSH_MID = 18'h00020;
  localparam logic [CNT_W-1:0] FLUSH_LONG = 18'h00040;
  localparam logic [CNT_W-1:0] HALT_FLUSH = 18'h00020;
  localparam logic [CNT_W-1:0] STBY_WAKE_FAST = 18'h0000C;
  localparam logic [CNT_W-1:0] STBY_WAKE_FLASH = 18'h00465;
  localparam logic [CNT_W-1:0] PLL_LOCK_CYCLES = 18'h20000;
  localparam logic [5:0] EXT_CLK_STOP = 6'h20;
  localparam logic [6:0] QUAL_BASE = 7'h02;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic irq;
    logic watchdog;
    logic nmi;
    logic reset;
  } wake_src_t;

  typedef struct packed {
    logic sys;
    logic periph;
    logic core;
    logic osc;
    logic pll;
    logic watchdog;
  } clk_gate_t;

  localparam clk_gate_t GATES_RUN = 6'h3F;

  typedef enum logic [7:0] {
    ST_RUN = 8'h01,
    ST_SB_FLUSH = 8'h02,
    ST_SB_SLEEP = 8'h04,
    ST_SB_WAKE = 8'h08,
    ST_HT_FLUSH = 8'h10,
    ST_HT_SLEEP = 8'h20,
    ST_HT_OSC = 8'h40,
    ST_HT_LOCK = 8'h80
  } lpm_state_t;

endpackage : lpm_seq_pkg

// *** lpm_sequencer.sv ***
// low-power standby/halt clock sequencer
`timescale 1ns/10ps
module lpm_sequencer
  import lpm_seq_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOCK_CYCLES = PLL_LOCK_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic IDLE_EXEC,
  input wire logic [1:0] LOW_POWER_MODE,
  input wire logic [1:0] PLL_DIVIDE_SELECT,
  input wire logic QUALIFY_ENABLE,
  input wire logic [5:0] STANDBY_WAKE_QUALIFY_COUNT,
  input wire logic FLASH_ASLEEP,
  input wire logic WAKE_IRQ_ENABLE,
  input wire wake_src_t WAKE_SOURCES,
  output logic [0:0] EXTERNAL_CLOCK_OUTPUT,
  output clk_gate_t CLK_GATES,
  output logic STANDBY_ACTIVE,
  output logic HALT_ACTIVE,
  output logic RESUME,
  output logic SERVICE_WAKE
);

  // =====================================================================
  // elaboration checks
  if (LOCK_CYCLES < 18'h00002) begin : g_bad_lock
    $error("LOCK_CYCLES must be at least 2");
  end

  // =====================================================================
  // state
  typedef struct packed {
    lpm_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [6:0] qual_cnt;
    logic [5:0] ext_cnt;
    logic ext_clk;
    clk_gate_t gates;
    logic standby;
    logic halt;
    logic resume;
    logic service;
  } seq_t;

  seq_t cur;
  seq_t next_cur;

  logic any_wake;
  logic halt_wake;
  logic [CNT_W-1:0] flush_len;
  logic [CNT_W-1:0] wake_len;
  logic [6:0] qual_len;

  // any of the four sources wakes standby; halt has no clock for the
  // interrupt logic, so only the pins can wake it
  assign any_wake = |WAKE_SOURCES;
  assign halt_wake = WAKE_SOURCES.nmi | WAKE_SOURCES.reset;

  always_comb begin
    unique case (PLL_DIVIDE_SELECT)
      DIV_HALF: flush_len = FLUSH_MID;
      DIV_FULL: flush_len = FLUSH_LONG;
      default: flush_len = FLUSH_SHORT;
    endcase
  end

  // sleeping flash needs the long wake count
  assign wake_len = FLASH_ASLEEP ? STBY_WAKE_FLASH : STBY_WAKE_FAST;
  assign qual_len = QUAL_BASE + {1'b0, STANDBY_WAKE_QUALIFY_COUNT};

  // =====================================================================
  // sequencing
  always_comb begin
    next_cur = cur;
    next_cur.resume = 1'b0;
    next_cur.service = 1'b0;
    // external clock runs at half rate until it parks high after idle
    if (cur.state == ST_RUN) begin
      next_cur.ext_cnt = 6'h00;
      next_cur.ext_clk = ~cur.ext_clk;
    end else if (cur.ext_cnt < EXT_CLK_STOP - 6'h01) begin
      next_cur.ext_cnt = cur.ext_cnt + 6'h01;
      next_cur.ext_clk = ~cur.ext_clk;
    end else begin
      next_cur.ext_clk = 1'b1;
    end
    unique case (cur.state)
      ST_RUN: begin
        next_cur.gates = GATES_RUN;
        next_cur.cnt = '0;
        if (IDLE_EXEC && LOW_POWER_MODE == MODE_STANDBY) begin
          next_cur.state = ST_SB_FLUSH;
          next_cur.ext_cnt = 6'h01;
        end else if (IDLE_EXEC && LOW_POWER_MODE == MODE_HALT) begin
          next_cur.state = ST_HT_FLUSH;
          next_cur.ext_cnt = 6'h01;
        end
      end
      ST_SB_FLUSH: begin
        // the hold lets the pipeline drain; a slow external access that
        // outlasts it is lost, which software has to avoid
        next_cur.cnt = cur.cnt + 18'h00001;
        if (cur.cnt + 18'h00001 >= flush_len) begin
          next_cur.state = ST_SB_SLEEP;
          next_cur.gates.sys = 1'b0;
          next_cur.gates.core = 1'b0;
          next_cur.gates.periph = 1'b0;
          next_cur.standby = 1'b1;
          next_cur.qual_cnt = 7'h00;
        end
      end
      ST_SB_SLEEP: begin
        // pll and watchdog stay up so wake needs no relock
        next_cur.gates.pll = 1'b1;
        next_cur.gates.watchdog = 1'b1;
        if (!any_wake) begin
          next_cur.qual_cnt = 7'h00;
        end else if (!QUALIFY_ENABLE ||
                     cur.qual_cnt + 7'h01 >= qual_len) begin
          next_cur.state = ST_SB_WAKE;
          next_cur.cnt = wake_len - 18'h00003;
          next_cur.gates.sys = 1'b1;
          next_cur.gates.core = 1'b1;
        end else begin
          next_cur.qual_cnt = cur.qual_cnt + 7'h01;
        end
      end
      ST_SB_WAKE: begin
        if (cur.cnt == '0) begin
          next_cur.state = ST_RUN;
          next_cur.gates = GATES_RUN;
          next_cur.standby = 1'b0;
          next_cur.resume = 1'b1;
          next_cur.service = WAKE_IRQ_ENABLE;
        end else begin
          next_cur.cnt = cur.cnt - 18'h00001;
        end
      end
      ST_HT_FLUSH: begin
        next_cur.cnt = cur.cnt + 18'h00001;
        if (cur.cnt + 18'h00001 >= HALT_FLUSH) begin
          next_cur.state = ST_HT_SLEEP;
          next_cur.gates = '0;
          next_cur.halt = 1'b1;
        end
      end
      ST_HT_SLEEP: begin
        // pulse width is the board's job; any sampled level counts
        if (halt_wake) begin
          next_cur.state = ST_HT_OSC;
          next_cur.gates.osc = 1'b1;
        end
      end
      ST_HT_OSC: begin
        // with the internal oscillator the pin is held through start-up
        if (!halt_wake) begin
          next_cur.state = ST_HT_LOCK;
          next_cur.gates.pll = 1'b1;
          next_cur.cnt = LOCK_CYCLES - 18'h00001;
        end
      end
      ST_HT_LOCK: begin
        if (cur.cnt == '0) begin
          next_cur.state = ST_RUN;
          next_cur.gates = GATES_RUN;
          next_cur.halt = 1'b0;
          next_cur.resume = 1'b1;
          next_cur.service = WAKE_IRQ_ENABLE;
        end else begin
          next_cur.cnt = cur.cnt - 18'h00001;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cur <= '{state: ST_RUN, cnt: '0, qual_cnt: 7'h00, ext_cnt: 6'h00,
               ext_clk: 1'b0, gates: GATES_RUN, standby: 1'b0,
               halt: 1'b0, resume: 1'b0, service: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // =====================================================================
  // outputs, all straight from the state register
  assign EXTERNAL_CLOCK_OUTPUT = cur.ext_clk;
  assign CLK_GATES = cur.gates;
  assign STANDBY_ACTIVE = cur.standby;
  assign HALT_ACTIVE = cur.halt;
  assign RESUME = cur.resume;
  assign SERVICE_WAKE = cur.service;

endmodule : lpm_sequencer

// *** lpm_sequencer_sva.sv ***
// port assertions of the low-power sequencer
`timescale 1ns/10ps
module lpm_sequencer_sva
  import lpm_seq_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOCK_CYCLES = PLL_LOCK_CYCLES
) (
  input logic REF_CLK,
  input logic RST,
  input logic IDLE_EXEC,
  input logic [1:0] LOW_POWER_MODE,
  input logic [1:0] PLL_DIVIDE_SELECT,
  input logic QUALIFY_ENABLE,
  input logic FLASH_ASLEEP,
  input logic WAKE_IRQ_ENABLE,
  input wake_src_t WAKE_SOURCES,
  input logic [0:0] EXTERNAL_CLOCK_OUTPUT,
  input clk_gate_t CLK_GATES,
  input logic STANDBY_ACTIVE,
  input logic HALT_ACTIVE,
  input logic RESUME,
  input logic SERVICE_WAKE
);
  // ==================================================================
  // helpers
  localparam int LK = int'(LOCK_CYCLES);
  localparam int LKM = LK - 1;
  logic run;
  logic take;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  assign take = IDLE_EXEC && run && LOW_POWER_MODE inside {2'h1, 2'h2};
  // a new idle counts only from run, so track it here
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) run <= 1'h1;
    else if (take) run <= 1'h0;
    else if (RESUME) run <= 1'h1;
  end
  sequence sb_asleep;
    STANDBY_ACTIVE && CLK_GATES == 6'h07;
  endsequence
  sequence back_up;
    RESUME && CLK_GATES == GATES_RUN && !STANDBY_ACTIVE && !HALT_ACTIVE;
  endsequence
  a_run_gates_on: assert property (
    run && !take |=> CLK_GATES == GATES_RUN) else $error("gated in run");
  a_sb_short_flush: assert property (
    take && LOW_POWER_MODE == MODE_STANDBY && PLL_DIVIDE_SELECT < DIV_HALF
    |-> ##16 !STANDBY_ACTIVE ##1 sb_asleep) else $error("flush wrong");
  a_ext_clk_park: assert property (
    take |-> ##33 EXTERNAL_CLOCK_OUTPUT[*8]) else $error("ext clk low");
  a_halt_entry: assert property (
    take && LOW_POWER_MODE == MODE_HALT |-> ##32 !HALT_ACTIVE
    ##1 (HALT_ACTIVE && CLK_GATES == 6'h00)) else $error("halt entry");
  a_halt_osc_on: assert property (
    HALT_ACTIVE && !CLK_GATES.osc && (WAKE_SOURCES.nmi || WAKE_SOURCES.reset)
    |=> CLK_GATES.osc && !CLK_GATES.pll) else $error("osc not on");
  a_pll_lock_time: assert property (
    $rose(CLK_GATES.pll) && HALT_ACTIVE |-> ##[LKM:LK] back_up)
    else $error("lock time");
  a_sb_wake_time: assert property (
    STANDBY_ACTIVE && !CLK_GATES.sys && WAKE_SOURCES != 4'h0
    && !QUALIFY_ENABLE && !FLASH_ASLEEP
    |=> CLK_GATES.sys && CLK_GATES.core ##[8:10] back_up)
    else $error("standby wake");
  a_service_pair: assert property (
    RESUME || SERVICE_WAKE |-> RESUME && SERVICE_WAKE == WAKE_IRQ_ENABLE)
    else $error("service pulse");
endmodule : lpm_sequencer_sva

// *** lpm_wake_src.sv ***
// board-side wake sources of the sequencer
`timescale 1ns/10ps
module lpm_wake_src
  import lpm_seq_pkg::*;
#(
  parameter int OSC_START = 4
) (
  input wire logic clk,
  output wake_src_t wake
);
  // ==================================================================
  // pulse generator
  initial wake = 4'h0;
  // held for n edges, n plus OSC_START for nmi; the board owns the minimum widths
  task automatic pulse(input wake_src_t w, input int n);
    int k;
    k = w.nmi ? n + OSC_START : n;
    @(posedge clk) wake <= w;
    repeat (k) @(posedge clk);
    wake <= 4'h0;
  endtask : pulse
endmodule : lpm_wake_src

// *** lpm_sequencer_tb.sv ***
// testbench of the low-power sequencer
`timescale 1ns/10ps
module lpm_sequencer_tb
  import lpm_seq_pkg::*;
;
  // ==================================================================
  // bench
  logic REF_CLK = 1'h0;
  logic RST = 1'h1;
  logic IDLE_EXEC = 1'h0;
  logic [1:0] LOW_POWER_MODE = 2'h0;
  logic [1:0] PLL_DIVIDE_SELECT = 2'h0;
  logic QUALIFY_ENABLE = 1'h0;
  logic [5:0] STANDBY_WAKE_QUALIFY_COUNT = 6'h03;
  logic FLASH_ASLEEP = 1'h0;
  logic WAKE_IRQ_ENABLE = 1'h1;
  wake_src_t WAKE_SOURCES;
  logic [0:0] EXTERNAL_CLOCK_OUTPUT;
  clk_gate_t CLK_GATES;
  logic STANDBY_ACTIVE, HALT_ACTIVE, RESUME, SERVICE_WAKE;
  int err_total = 0;
  int n_compared = 0;
  always #25 REF_CLK = ~REF_CLK;
  lpm_sequencer #(.LOCK_CYCLES(18'h00008)) lpm_sequencer_i (.REF_CLK, .RST,
    .IDLE_EXEC, .LOW_POWER_MODE, .PLL_DIVIDE_SELECT, .QUALIFY_ENABLE,
    .STANDBY_WAKE_QUALIFY_COUNT, .FLASH_ASLEEP, .WAKE_IRQ_ENABLE,
    .WAKE_SOURCES, .EXTERNAL_CLOCK_OUTPUT, .CLK_GATES, .STANDBY_ACTIVE,
    .HALT_ACTIVE, .RESUME, .SERVICE_WAKE);
  lpm_wake_src lpm_wake_src_i (.clk(REF_CLK), .wake(WAKE_SOURCES));
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [31:0] exp, got,
      input bit le = 1'b0);
    n_compared++;
    if (le ? got > exp : got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  task automatic wait_on(input int sel, output int n);
    n = 0;
    while ((sel == 0 ? STANDBY_ACTIVE : sel == 1 ? HALT_ACTIVE : RESUME)
        !== 1'h1 && n < 3000) begin
      @(posedge REF_CLK);
      #1;
      n++;
    end
    if (n == 3000) begin
      err_total++;
      results();
    end
  endtask : wait_on
  task automatic idle(input logic [1:0] mode);
    @(posedge REF_CLK);
    LOW_POWER_MODE <= mode;
    IDLE_EXEC <= 1'h1;
    @(posedge REF_CLK);
    IDLE_EXEC <= 1'h0;
    #1;
  endtask : idle
  task automatic t_standby(input logic [1:0] div, input int flush,
      input logic slow, input wake_src_t src);
    int n;
    int w;
    w = slow ? 5 : 12;
    @(posedge REF_CLK);
    PLL_DIVIDE_SELECT <= div;
    FLASH_ASLEEP <= slow;
    QUALIFY_ENABLE <= slow;
    idle(MODE_STANDBY);
    wait_on(0, n);
    chk("flush", flush, n);
    chk("standby gates", 6'h07, CLK_GATES);
    repeat (45) @(posedge REF_CLK);
    #1;
    chk("ext clock", 1'h1, EXTERNAL_CLOCK_OUTPUT);
    // a qualified wake one sample short of 2 plus count must be ignored
    if (slow) begin
      lpm_wake_src_i.pulse(4'h8, 4);
      repeat (2) @(posedge REF_CLK);
      #1;
      chk("short qualified wake", 1'h0, CLK_GATES.sys);
    end
    fork lpm_wake_src_i.pulse(src, w); join_none
    wait_on(2, n);
    chk("wake latency", slow ? 1125 + w : 12, n, 1'b1);
    chk("service", 1'h1, SERVICE_WAKE);
    repeat (w) @(posedge REF_CLK);
    $display("standby test done");
  endtask : t_standby
  task automatic t_halt(input wake_src_t src, input int w, input logic ie);
    int n;
    @(posedge REF_CLK);
    WAKE_IRQ_ENABLE <= ie;
    idle(MODE_HALT);
    wait_on(1, n);
    chk("halt entry", 32, n);
    chk("halt gates", 6'h00, CLK_GATES);
    lpm_wake_src_i.pulse(4'hC, 3);
    #1;
    chk("osc by irq", 1'h0, CLK_GATES.osc);
    fork lpm_wake_src_i.pulse(src, w); join_none
    repeat (3) @(posedge REF_CLK);
    #1;
    chk("osc on pll off", 6'h04, CLK_GATES);
    wait_on(2, n);
    chk("lock", w + 14, n, 1'b1);
    chk("resume gates", 6'h3F, CLK_GATES);
    chk("service", ie, SERVICE_WAKE);
    $display("halt test done");
  endtask : t_halt
  initial begin
    repeat (2) @(posedge REF_CLK);
    chk("reset gates", 6'h3F, CLK_GATES);
    RST <= 1'h0;
    idle(MODE_IDLE);
    repeat (40) @(posedge REF_CLK);
    chk("refused idle", 6'h3F, CLK_GATES);
    t_standby(2'h0, 16, 1'h0, 4'h8);
    t_standby(2'h1, 16, 1'h0, 4'h8);
    t_standby(2'h2, 32, 1'h0, 4'h8);
    t_standby(2'h3, 64, 1'h0, 4'h4);
    t_standby(2'h0, 16, 1'h1, 4'h2);
    t_halt(4'h2, 2, 1'h0);
    t_halt(4'h1, 8, 1'h1);
    results();
  end
endmodule : lpm_sequencer_tb
bind lpm_sequencer lpm_sequencer_sva #(.LOCK_CYCLES(LOCK_CYCLES)) sva_i (
  .REF_CLK, .RST, .IDLE_EXEC, .LOW_POWER_MODE, .PLL_DIVIDE_SELECT,
  .QUALIFY_ENABLE, .FLASH_ASLEEP, .WAKE_IRQ_ENABLE, .WAKE_SOURCES,
  .EXTERNAL_CLOCK_OUTPUT, .CLK_GATES, .STANDBY_ACTIVE, .HALT_ACTIVE,
  .RESUME, .SERVICE_WAKE);
